/* logic/fdc_status.sv */
// Contract
// RULE_01 - mark mismatch sets status2 bit 6
// RULE_02 - data field crc error sets bit 5
// RULE_03 - track mismatch sets bit 4
// RULE_04 - mismatch and track ff sets bit 1
// RULE_05 - no data mark sets bit 0
// RULE_06 - status2 bits 7,3,2, status3 bit 7 zero
// RULE_07 - status3 bits 5 and 3 one
// RULE_08 - status3 mirrors wp, track_zero_input, head, drive pins
// RULE_09 - three reset sources, all end power-down
// RULE_10 - reset aborts, clears config, goes idle
// RULE_11 - polling starts after reset unless disabled
// RULE_12 - pin reset sets output-register reset, keeps specify; the code clears dma_en_q on pin reset
// RULE_13 - rate reset self-clears, output reset persists, wins
// RULE_14 - config bits 3 and 2 pick mode
// RULE_15 - interface bit high: enable honoured, tc/density high
// RULE_16 - ps2 style: enable ignored, always drive, low
// RULE_17 - both low: enable honoured, tc high, density low
// RULE_18 - dma request in transfers, ack selects fifo
// RULE_19 - verify pseudo read on ack, byte mode read
// RULE_20 - single drops after ack, burst holds
// RULE_21 - config bit 1 zero means burst
// RULE_22 - command, execution, result phases in turn
// RULE_23 - status bytes read in result phase
// RULE_24 - error flags cleared at command start
// RULE_25 - pin status sampled when assembled
`timescale 1ns/10ps
`default_nettype none

module fdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic clr,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q < (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  always_ff @(posedge clk) begin
    if (clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module fdc_status
  import fdc_status_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic sys_rst,
  input wire logic [7:0] controller_config_byte,
  input wire logic ctrl_reset_set,
  input wire logic ctrl_reset_clr,
  input wire logic ctrl_dma_enable,
  input wire logic rate_reset_set,
  input wire logic specify_wr,
  input wire logic specify_dma,
  input wire logic configure_wr,
  input wire logic configure_no_poll,
  input wire logic configure_fifo_on,
  input wire logic cmd_start,
  input wire logic cmd_params_done,
  input wire logic cmd_is_read,
  input wire logic cmd_is_xfer,
  input wire logic exec_done,
  input wire logic result_done,
  input wire logic powerdown_req,
  input wire logic rd_is_deleted_cmd,
  input wire logic mark_seen,
  input wire logic mark_deleted,
  input wire logic mark_missing,
  input wire logic crc_check,
  input wire logic crc_bad,
  input wire logic id_seen,
  input wire logic [7:0] id_track,
  input wire logic [7:0] cur_track,
  input wire logic write_protect_in,
  input wire logic track_zero_input,
  input wire logic head_select_output,
  input wire logic [1:0] drive_select_output,
  input wire logic [1:0] result_sel,
  input wire logic disk_valid,
  input wire logic [7:0] disk_data,
  output logic disk_ready,
  input wire logic last_xfer,
  input wire logic dma_acknowledge_n,
  input wire logic terminal_count_in,
  input wire logic interrupt_req,
  output logic [7:0] result_byte,
  output logic [7:0] media_error_status,
  output logic [7:0] drive_pin_status,
  output logic [7:0] host_data,
  output logic host_strobe,
  output logic pseudo_read,
  output logic tc_active,
  output logic core_reset,
  output logic ctrl_reset_bit,
  output logic powered_down,
  output logic polling_on,
  output logic dma_mode_on,
  output logic fifo_on,
  output logic [1:0] phase,
  output logic [1:0] mode,
  input wire logic density_high,
  output logic density_select_out,
  output logic interrupt_request_out,
  output logic interrupt_request_oe,
  output logic dma_request_out,
  output logic dma_request_oe
);
  phase_e ph_q, ph_d;
  logic ctl_rst_q, rate_rst_q, pd_q, poll_q, dma_en_q, fifo_q, drq_q;
  logic [7:0] st2_q, st3_q, rb_q, hd_q;
  logic hs_q;

  // rate reset is one-shot; the control reset bit persists and wins
  assign core_reset = ctl_rst_q || rate_rst_q; // see RULE_13
  assign ctrl_reset_bit = ctl_rst_q;
  assign powered_down = pd_q;
  assign polling_on = poll_q;
  assign dma_mode_on = dma_en_q;
  assign fifo_on = fifo_q;
  assign phase = ph_q;

  wire ident = controller_config_byte[IDENT_BIT]; // see RULE_14
  wire style = controller_config_byte[STYLE_BIT]; // see RULE_14
  wire burst = !controller_config_byte[BURST_N_BIT]; // see RULE_21
  wire mode_ps2 = !ident && style;
  assign mode = ident ? MODE_AT : (style ? MODE_PS2 : MODE_M30);
  // ps2 style ignores the enable bit and always drives the pins
  wire gate_on = mode_ps2 || ctrl_dma_enable; // see RULE_15
  assign interrupt_request_oe = gate_on; // see RULE_16
  assign dma_request_oe = gate_on; // see RULE_17
  assign interrupt_request_out = interrupt_req;
  assign dma_request_out = drq_q;
  assign tc_active = mode_ps2 ? !terminal_count_in : terminal_count_in; // see RULE_15
  assign density_select_out = ident ? density_high : !density_high; // see RULE_16

  wire ack = !dma_acknowledge_n;
  wire xfer_exec = (ph_q == PH_EXEC) && cmd_is_xfer && dma_en_q;
  // verify cycles are a pseudo read only in byte mode
  assign pseudo_read = ack && xfer_exec && !fifo_q && cmd_is_read; // see RULE_19

  // pin snapshot is taken at assembly so the host sees pins as they were then, not at read time
  wire [7:0] st3_now = {1'b0, write_protect_in, 1'b1, track_zero_input,
    1'b1, head_select_output, drive_select_output}; // see RULE_08
  wire mark_err = mark_seen && (mark_deleted != rd_is_deleted_cmd); // see RULE_01
  wire trk_err = id_seen && (id_track != cur_track); // see RULE_03
  wire bad_trk = trk_err && (id_track == BAD_TRACK); // see RULE_04
  wire [7:0] st2_set = {1'b0, mark_err, crc_check && crc_bad, trk_err,
    2'b00, bad_trk, mark_missing}; // see RULE_06

  always_comb begin
    ph_d = ph_q;
    case (ph_q)
      PH_IDLE: if (cmd_start) ph_d = PH_CMD;
      PH_CMD: if (cmd_params_done) ph_d = PH_EXEC;
      PH_EXEC: if (exec_done) ph_d = PH_RESULT;
      PH_RESULT: if (result_done) ph_d = PH_IDLE;
      default: ph_d = PH_IDLE;
    endcase
  end

  wire fifo_vld;
  wire [7:0] fifo_dat;
  wire fifo_take = ack && xfer_exec && !pseudo_read; // see RULE_18
  fdc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .ce(ce),
    .clr(sys_rst || core_reset), // see RULE_13
    .in_data(disk_data),
    .in_valid(disk_valid),
    .in_ready(disk_ready),
    .out_data(fifo_dat),
    .out_valid(fifo_vld),
    .out_ready(fifo_take)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_rst_q <= 1'b1; // see RULE_12
      dma_en_q <= 1'b0;
    end else if (ce) begin
      if (ctrl_reset_set) ctl_rst_q <= 1'b1;
      else if (ctrl_reset_clr) ctl_rst_q <= 1'b0; // see RULE_12
      if (specify_wr) dma_en_q <= specify_dma;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_rst_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (ce) begin
      rate_rst_q <= rate_reset_set; // see RULE_13
      if (core_reset || rate_reset_set || ctrl_reset_set) pd_q <= 1'b0; // see RULE_09
      else if (powerdown_req) pd_q <= 1'b1;
    end
  end

  // specify settings survive control and rate resets, not pin reset; everything else restarts here
  always_ff @(posedge clk) begin
    if (sys_rst || core_reset) begin
      ph_q <= PH_IDLE; // see RULE_10
      poll_q <= 1'b1; // see RULE_11
      fifo_q <= 1'b0;
      st2_q <= '0;
      st3_q <= ST3_RESET; // see RULE_07
      rb_q <= '0;
      drq_q <= 1'b0;
      hd_q <= '0;
      hs_q <= 1'b0;
    end else if (ce) begin
      ph_q <= ph_d; // see RULE_22
      if (configure_wr) begin
        poll_q <= !configure_no_poll; // see RULE_11
        fifo_q <= configure_fifo_on;
      end
      if (cmd_start && ph_q == PH_IDLE) st2_q <= '0; // see RULE_24
      else st2_q <= st2_q | st2_set; // see RULE_02
      if (result_sel == RES_PINS) st3_q <= st3_now; // see RULE_25
      if (ph_q == PH_RESULT) begin
        rb_q <= (result_sel == RES_MEDIA) ? st2_q : st3_q; // see RULE_23
      end
      // single mode drops on ack, burst holds to the last byte
      if (!xfer_exec) drq_q <= 1'b0;
      else if (burst) drq_q <= !(last_xfer && ack); // see RULE_20
      else drq_q <= !ack; // see RULE_20
      hs_q <= fifo_take && fifo_vld;
      if (fifo_take && fifo_vld) hd_q <= fifo_dat; // see RULE_18
    end
  end

  assign media_error_status = st2_q;
  assign drive_pin_status = st3_q;
  assign result_byte = rb_q;
  assign host_data = hd_q;
  assign host_strobe = hs_q;

  crc_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_02
    (ce && !core_reset && crc_check && crc_bad && !(cmd_start && ph_q == PH_IDLE))
    |=> st2_q[CRC_BIT])
    else $error("crc flag not set");
  bad_track_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_04
    st2_q[BTRK_BIT] |-> st2_q[WTRK_BIT])
    else $error("bad track without wrong track");
  fixed_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_06
    st2_q[7] == 1'b0 && st2_q[3:2] == 2'b00 && st3_q[7] == 1'b0)
    else $error("reserved bits not zero");
  pin_snap_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_08
    (ce && !core_reset && result_sel == RES_PINS) |=> st3_q == $past(st3_now))
    else $error("pin snapshot wrong");
  reset_pin_a: assert property (@(posedge clk) // see RULE_12
    sys_rst |=> ctl_rst_q && ph_q == PH_IDLE)
    else $error("pin reset did not set control reset");
  rate_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_13
    (ce && rate_reset_set) ##1 (ce && !rate_reset_set) |=> !rate_rst_q)
    else $error("rate reset did not clear");
  ps2_drive_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_16
    mode_ps2 |-> dma_request_oe && interrupt_request_oe
      && (tc_active == !terminal_count_in))
    else $error("ps2 style pin behaviour");
  single_drop_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_20
    (ce && !core_reset && !burst && ack) |=> !drq_q)
    else $error("single request held after ack");

  mark_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_01
    (ce && !core_reset && mark_err && !(cmd_start && ph_q == PH_IDLE)) |=> st2_q[MARK_BIT])
    else $error("control mark flag not set");

  wrong_track_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_03
    (ce && !core_reset && trk_err && !(cmd_start && ph_q == PH_IDLE)) |=> st2_q[WTRK_BIT])
    else $error("wrong track flag not set");

  missing_mark_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_05
    (ce && !core_reset && mark_missing && !(cmd_start && ph_q == PH_IDLE)) |=> st2_q[MDAM_BIT])
    else $error("missing mark flag not set");

  status3_ones_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_07
    st3_q[ONE_HI_BIT] && st3_q[ONE_LO_BIT])
    else $error("status3 fixed ones missing");

  phase_cmd_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_22
    (ce && !core_reset && ph_q == PH_IDLE && cmd_start) |=> ph_q == PH_CMD)
    else $error("command phase not entered");

  phase_exec_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_22
    (ce && !core_reset && ph_q == PH_CMD && cmd_params_done) |=> ph_q == PH_EXEC)
    else $error("execution phase not entered");

  phase_result_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_22
    (ce && !core_reset && ph_q == PH_EXEC && exec_done) |=> ph_q == PH_RESULT)
    else $error("result phase not entered");

  phase_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_22
    (ce && !core_reset && ph_q == PH_RESULT && result_done) |=> ph_q == PH_IDLE)
    else $error("idle not reached after result");

  err_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_24
    (ce && !core_reset && cmd_start && ph_q == PH_IDLE) |=> st2_q == 8'h00)
    else $error("error flags not cleared at command start");

  core_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_10
    core_reset |=> ph_q == PH_IDLE && !drq_q && !fifo_q)
    else $error("core reset did not go idle");

  poll_restart_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_11
    core_reset |=> polling_on)
    else $error("polling not restarted by reset");

  pd_exit_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_09
    (ce && (rate_reset_set || ctrl_reset_set)) |=> !pd_q)
    else $error("reset did not end power-down");

  ctl_persist_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_13
    (ctl_rst_q && !(ce && ctrl_reset_clr)) |=> ctl_rst_q)
    else $error("control reset bit cleared itself");

  spec_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_12
    (core_reset && !(ce && specify_wr)) |=> dma_en_q == $past(dma_en_q))
    else $error("specify setting lost in core reset");

  at_polarity_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_15
    ident |-> tc_active == terminal_count_in && density_select_out == density_high)
    else $error("interface style polarity wrong");

  m30_polarity_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_17
    (!ident && !style) |-> tc_active == terminal_count_in
      && density_select_out == !density_high && dma_request_oe == ctrl_dma_enable)
    else $error("both-low mode pin behaviour");

  pseudo_read_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_19
    (fifo_q || !cmd_is_read) |-> !pseudo_read)
    else $error("pseudo read outside byte mode read");

  burst_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_20
    (ce && !core_reset && burst && xfer_exec && !last_xfer) |=> drq_q)
    else $error("burst request dropped early");

  ack_fifo_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_18
    (ce && !core_reset && fifo_take && fifo_vld) |=> host_strobe && host_data == $past(fifo_dat))
    else $error("ack did not deliver fifo byte");

  result_load_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_23
    (ce && !core_reset && ph_q == PH_RESULT && result_sel == RES_MEDIA)
      |=> result_byte == $past(st2_q))
    else $error("result byte not loaded");
endmodule

`default_nettype wire

/* logic/fdc_status_pkg.sv */
package fdc_status_pkg;
  // second status byte, bit positions
  localparam int MARK_BIT = 6;
  localparam int CRC_BIT = 5;
  localparam int WTRK_BIT = 4;
  localparam int BTRK_BIT = 1;
  localparam int MDAM_BIT = 0;
  // third status byte, bit positions
  localparam int WP_BIT = 6;
  localparam int TRACK_ZERO_INPUT_BIT = 4;
  localparam int HEAD_BIT = 2;
  localparam int ONE_HI_BIT = 5;
  localparam int ONE_LO_BIT = 3;
  // configuration byte fields
  localparam int IDENT_BIT = 3;
  localparam int STYLE_BIT = 2;
  localparam int BURST_N_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h02;
  localparam logic [7:0] BAD_TRACK = 8'hff;
  localparam logic [7:0] ST3_RESET = 8'h28;
  // result byte select codes
  localparam logic [1:0] RES_MEDIA = 2'h1;
  localparam logic [1:0] RES_PINS = 2'h2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_EXEC = 2'b10,
    PH_RESULT = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    MODE_AT = 2'b00,
    MODE_PS2 = 2'b01,
    MODE_M30 = 2'b10
  } mode_e;
endpackage

/* test/dma_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none

module dma_ctrl_model (
  input wire logic clk,
  input wire logic dma_request_out,
  input wire logic [3:0] lat,
  output logic dma_acknowledge_n
);
  logic [3:0] wait_q;
  initial begin
    dma_acknowledge_n = 1'b1;
    wait_q = 4'h0;
  end
  // one-cycle ack per request, back to idle high, lat stalls it
  always @(posedge clk) begin
    if (!dma_acknowledge_n) begin
      dma_acknowledge_n <= 1'b1;
      wait_q <= 4'h0;
    end else if (dma_request_out && wait_q >= lat) begin
      dma_acknowledge_n <= 1'b0;
    end else if (dma_request_out) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import fdc_status_pkg::*;
  logic clk, ce, sys_rst, ctrl_reset_set, ctrl_reset_clr, ctrl_dma_enable, rate_reset_set;
  logic specify_wr, specify_dma, configure_wr, configure_no_poll, configure_fifo_on;
  logic cmd_start, cmd_params_done, cmd_is_read, cmd_is_xfer, exec_done, result_done;
  logic powerdown_req, rd_is_deleted_cmd, mark_seen, mark_deleted, mark_missing;
  logic crc_check, crc_bad, id_seen, write_protect_in, track_zero_input, head_select_output;
  logic disk_valid, disk_ready, last_xfer, dma_acknowledge_n, terminal_count_in;
  logic interrupt_req, host_strobe, pseudo_read, tc_active, core_reset, ctrl_reset_bit;
  logic powered_down, polling_on, dma_mode_on, fifo_on, density_high, density_select_out;
  logic interrupt_request_out, interrupt_request_oe, dma_request_out, dma_request_oe;
  logic [7:0] controller_config_byte, id_track, cur_track, disk_data, result_byte;
  logic [7:0] media_error_status, drive_pin_status, host_data;
  logic [1:0] drive_select_output, result_sel, phase, mode;
  logic [3:0] lat;
  logic [4:0] pins;
  logic [7:0] st3_exp;
  int checks, n_mismatch, nrx;
  bit burst, watch;
  // {del cmd, mark, deleted, missing, crc chk, crc bad, id, id track, status}
  localparam logic [22:0] ROWS [9] = '{{7'h30, 8'h00, 8'h40}, {7'h60, 8'h00, 8'h40},
    {7'h20, 8'h00, 8'h00}, {7'h06, 8'h00, 8'h20}, {7'h04, 8'h00, 8'h00},
    {7'h01, 8'h07, 8'h10}, {7'h01, 8'hff, 8'h12}, {7'h01, 8'h05, 8'h00},
    {7'h08, 8'h00, 8'h01}};
  // {cfg 3:2, mode, density, tc, oe} with density and tc pins high, dma enable low
  localparam logic [6:0] MODES [4] = '{7'h66, 7'h46, 7'h29, 7'h12};

  fdc_status fdc_status_i (.*);
  dma_ctrl_model dma_ctrl_model_i (.clk(clk), .dma_request_out(dma_request_out), .lat(lat),
    .dma_acknowledge_n(dma_acknowledge_n));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc();
    @(negedge clk);
  endtask
  task automatic idle();
    {ctrl_reset_set, ctrl_reset_clr, rate_reset_set, specify_wr, configure_wr, cmd_start,
      cmd_params_done, exec_done, result_done, powerdown_req, mark_seen, mark_missing,
      crc_check, id_seen} = '0;
  endtask
  // pulses last one edge; the extra cycle keeps set and clear apart
  task automatic fire();
    cyc();
    idle();
    cyc();
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 100 && nrx < n; i++) cyc();
    chk("bytes", 8'(n), 8'(nrx));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // bytes leave in fifo order; single drops the request, burst holds it
  always @(negedge clk) begin
    if (watch && host_strobe) begin
      chk("host_data", 8'ha0 + 8'(nrx), host_data);
      chk("drq at byte", 8'(burst), 8'(dma_request_out));
      nrx++;
    end
  end
  initial begin
    #60000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    idle();
    {ctrl_dma_enable, specify_dma, configure_no_poll, configure_fifo_on, cmd_is_read,
      cmd_is_xfer, rd_is_deleted_cmd, mark_deleted, crc_bad, id_track, write_protect_in,
      track_zero_input, head_select_output, drive_select_output, result_sel, disk_data,
      last_xfer, interrupt_req, disk_valid} = '0;
    {ce, sys_rst, density_high, terminal_count_in, lat} = {4'hf, 4'h0};
    controller_config_byte = CFG_RESET;
    cur_track = 8'h05;
    repeat (6) cyc();
    sys_rst = 1'b0;
    cyc();
    chk("pin reset", 8'h1c, 8'({ctrl_reset_bit, core_reset, polling_on, phase}));
    ctrl_reset_clr = 1'b1;
    fire();
    chk("leave reset", 8'h0, 8'({ctrl_reset_bit, core_reset}));
    result_sel = RES_MEDIA;
    foreach (ROWS[i]) begin
      cmd_start = 1'b1;
      fire();
      chk("phase cmd", 8'h1, 8'(phase));
      {rd_is_deleted_cmd, mark_seen, mark_deleted, mark_missing, crc_check, crc_bad, id_seen,
        id_track} = ROWS[i][22:8];
      fire();
      chk("status2", ROWS[i][7:0], media_error_status);
      cmd_params_done = 1'b1;
      fire();
      exec_done = 1'b1;
      fire();
      chk("result media", ROWS[i][7:0], result_byte);
      result_done = 1'b1;
      fire();
      chk("phase idle", 8'h0, 8'(phase));
      chk("status2 held", ROWS[i][7:0], media_error_status);
    end
    result_sel = RES_PINS;
    foreach (MODES[i]) begin
      pins = 5'(i * 7 + 6);
      {write_protect_in, track_zero_input, head_select_output, drive_select_output} = pins;
      controller_config_byte = {4'h0, MODES[i][6:5], 2'h2};
      st3_exp = {1'b0, pins[4], 1'b1, pins[3], 1'b1, pins[2:0]};
      cyc();
      cyc();
      chk("status3", st3_exp, drive_pin_status);
      // walk to the result phase so the pin byte is loaded for reading
      cmd_start = 1'b1;
      fire();
      cmd_params_done = 1'b1;
      fire();
      exec_done = 1'b1;
      fire();
      chk("result", st3_exp, result_byte);
      result_done = 1'b1;
      fire();
      chk("mode", {3'h0, MODES[i][4:0]}, 8'({mode, density_select_out, tc_active,
        dma_request_oe}));
      chk("irq oe", 8'(MODES[i][0]), 8'(interrupt_request_oe));
    end
    specify_wr = 1'b1;
    specify_dma = 1'b1;
    {ctrl_dma_enable, controller_config_byte} = {1'b1, 8'h0a};
    fire();
    chk("dma oe", 8'h3, 8'({dma_mode_on, dma_request_oe}));
    disk_valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      disk_data = 8'ha0 + 8'(i);
      cyc();
    end
    chk("fifo full", 8'h0, 8'(disk_ready));
    disk_valid = 1'b0;
    {watch, lat, cmd_is_xfer, cmd_start} = {1'b1, 4'h3, 2'h3};
    fire();
    cmd_params_done = 1'b1;
    fire();
    wait_rx(2);
    lat = 4'h0;
    wait_rx(4);
    controller_config_byte = 8'h08;
    // strobes up to this edge were still judged in single mode
    @(posedge clk);
    burst = 1'b1;
    repeat (3) cyc();
    wait_rx(nrx + 3);
    {watch, last_xfer, exec_done} = 3'h3;
    fire();
    result_done = 1'b1;
    fire();
    {cmd_is_xfer, last_xfer, configure_wr, configure_no_poll, configure_fifo_on} = 5'h07;
    fire();
    chk("configure", 8'h1, 8'({polling_on, fifo_on}));
    powerdown_req = 1'b1;
    fire();
    chk("powered down", 8'h1, 8'(powered_down));
    rate_reset_set = 1'b1;
    fire();
    chk("rate reset", 8'h0c, 8'({powered_down, core_reset, ctrl_reset_bit, fifo_on, polling_on,
      dma_mode_on, phase}));
    {ctrl_reset_set, rate_reset_set} = 2'h3;
    fire();
    cyc();
    chk("both resets", 8'h3, 8'({core_reset, ctrl_reset_bit}));
    report_and_stop();
  end
endmodule

`default_nettype wire
